// >>> core/async_serial_tx_rx.sv
// async serial transmitter and receiver with wishbone register slave
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module async_serial_tx_rx #(
  parameter int DATA_BITS = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic baud_tick16,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic receive_pin,
  output logic transmit_pin_o,
  output logic transmit_pin_oe,
  output logic transmit_irq,
  output logic receive_irq
);
  if (DATA_BITS != 8)
  begin : g_bad
    $error("only eight low data bits are supported");
  end

  // --------------------------------------------------------------------------
  // register slave
  // --------------------------------------------------------------------------
  serial_pkg::tx_ctrl_t txc_q;
  serial_pkg::rx_ctrl_t rxc_q;
  logic req;
  logic wr;
  logic rd;
  logic [8:0] txbuf_q;
  logic txbuf_full_q;
  logic tx_busy_q;
  logic overrun_q;
  logic [1:0] fcount_q;
  serial_pkg::rx_entry_t fifo_q [2];
  logic frd_q;
  logic [31:0] rdata;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign rd = req && !wb_we_i;

  wire tx_on = txc_q.enable && !txc_q.sync_mode && rxc_q.port_en;
  wire rx_on = rxc_q.enable && !txc_q.sync_mode && rxc_q.port_en;
  wire tx_ready = tx_on && !txbuf_full_q;
  wire rx_ready = rx_on && (fcount_q != 2'h0);

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txc_q <= '0;
      rxc_q <= '0;
    end
    else if (wr && wb_adr_i == serial_pkg::ADDR_TX_CTRL)
    begin
      txc_q.enable <= wb_dat_i[serial_pkg::TXC_ENABLE];
      txc_q.sync_mode <= wb_dat_i[serial_pkg::TXC_SYNC];
      txc_q.nine <= wb_dat_i[serial_pkg::TXC_NINE];
      txc_q.ninth <= wb_dat_i[serial_pkg::TXC_NINTH];
      txc_q.invert <= wb_dat_i[serial_pkg::TXC_INVERT];
      txc_q.irq_en <= wb_dat_i[serial_pkg::TXC_IRQ_EN];
    end
    else if (wr && wb_adr_i == serial_pkg::ADDR_RX_CTRL)
    begin
      rxc_q.port_en <= wb_dat_i[serial_pkg::RXC_PORT_EN];
      rxc_q.enable <= wb_dat_i[serial_pkg::RXC_ENABLE];
      rxc_q.nine <= wb_dat_i[serial_pkg::RXC_NINE];
      rxc_q.irq_en <= wb_dat_i[serial_pkg::RXC_IRQ_EN];
      rxc_q.periph <= wb_dat_i[serial_pkg::RXC_PERIPH];
      rxc_q.global <= wb_dat_i[serial_pkg::RXC_GLOBAL];
    end
  end

  always_comb
  begin
    rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      serial_pkg::ADDR_TX_CTRL:
      begin
        rdata[serial_pkg::TXC_ENABLE] = txc_q.enable;
        rdata[serial_pkg::TXC_SYNC] = txc_q.sync_mode;
        rdata[serial_pkg::TXC_NINE] = txc_q.nine;
        rdata[serial_pkg::TXC_NINTH] = txc_q.ninth;
        rdata[serial_pkg::TXC_INVERT] = txc_q.invert;
        rdata[serial_pkg::TXC_IRQ_EN] = txc_q.irq_en;
        rdata[serial_pkg::TXC_EMPTY] = !tx_busy_q;
        rdata[serial_pkg::TXC_READY] = tx_ready;
      end
      serial_pkg::ADDR_RX_CTRL:
      begin
        rdata[serial_pkg::RXC_PORT_EN] = rxc_q.port_en;
        rdata[serial_pkg::RXC_ENABLE] = rxc_q.enable;
        rdata[serial_pkg::RXC_NINE] = rxc_q.nine;
        rdata[serial_pkg::RXC_IRQ_EN] = rxc_q.irq_en;
        rdata[serial_pkg::RXC_PERIPH] = rxc_q.periph;
        rdata[serial_pkg::RXC_GLOBAL] = rxc_q.global;
        rdata[serial_pkg::RXC_FRAME] = (fcount_q != 2'h0) && fifo_q[0].frame_err;
        rdata[serial_pkg::RXC_OVERRUN] = overrun_q;
        rdata[serial_pkg::RXC_READY] = rx_ready;
        rdata[serial_pkg::RXC_NINTH] = fifo_q[0].data[8];
      end
      serial_pkg::ADDR_RX_DATA:
        rdata[7:0] = fifo_q[0].data[7:0];
      default:
        rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      wb_dat_o <= 32'h0000_0000;
    else if (rd)
      wb_dat_o <= rdata;
  end

  // --------------------------------------------------------------------------
  // transmitter
  // --------------------------------------------------------------------------
  logic [9:0] tsr_q;
  logic [3:0] tx_bits_q;
  logic [3:0] tx_sub_q;
  logic tx_line_q;
  logic buf_write;
  logic tx_load;
  logic tx_bit_end;

  assign buf_write = wr && wb_adr_i == serial_pkg::ADDR_TX_DATA && tx_on;
  assign tx_bit_end = baud_tick16 && tx_sub_q == serial_pkg::TICKS_LAST;
  wire tx_last_bit = tx_bits_q == 4'h1;
  // shifter takes the buffer when idle, or right as the stop bit finishes
  assign tx_load = txbuf_full_q && (!tx_busy_q || (tx_bit_end && tx_last_bit));

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txbuf_q <= 9'h000;
      txbuf_full_q <= 1'b0;
    end
    else if (!tx_on)
      txbuf_full_q <= 1'b0;
    else if (buf_write)
    begin
      txbuf_q <= {txc_q.ninth, wb_dat_i[7:0]};
      txbuf_full_q <= 1'b1;
    end
    else if (tx_load)
      txbuf_full_q <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tsr_q <= 10'h3FF;
      tx_bits_q <= 4'h0;
      tx_sub_q <= 4'h0;
      tx_busy_q <= 1'b0;
    end
    else if (!tx_on)
    begin
      tsr_q <= 10'h3FF;
      tx_busy_q <= 1'b0;
      tx_bits_q <= 4'h0;
      tx_sub_q <= 4'h0;
    end
    else if (tx_load)
    begin
      // stop or ninth bit, data, start; start goes out first, LSB next, stop shifted in after the ninth bit
      tsr_q <= txc_q.nine ? {txbuf_q, 1'b0} : {1'b1, txbuf_q[7:0], 1'b0};
      tx_bits_q <= txc_q.nine ? 4'hB : 4'hA;
      tx_sub_q <= 4'h0;
      tx_busy_q <= 1'b1;
    end
    else if (tx_busy_q && baud_tick16)
    begin
      tx_sub_q <= tx_sub_q + 4'h1;
      if (tx_bit_end)
      begin
        tsr_q <= {1'b1, tsr_q[9:1]};
        tx_bits_q <= tx_bits_q - 4'h1;
        if (tx_last_bit)
          tx_busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_line_q <= 1'b1;
      transmit_pin_oe <= 1'b0;
      transmit_irq <= 1'b0;
    end
    else
    begin
      tx_line_q <= (tx_busy_q ? tsr_q[0] : 1'b1) ^ txc_q.invert;
      transmit_pin_oe <= rxc_q.port_en;
      transmit_irq <= tx_ready && txc_q.irq_en;
    end
  end
  assign transmit_pin_o = tx_line_q;

  // --------------------------------------------------------------------------
  // receiver
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  rx_state_t rx_state_q;
  logic [3:0] rx_sub_q;
  logic [3:0] rx_cnt_q;
  logic [8:0] rsr_q;
  logic [2:0] smp_q;
  logic rx_prev_q;
  logic vote;
  logic push;
  logic pop;
  logic stop_bit;
  logic [3:0] rx_nbits;

  assign vote = (smp_q[0] & smp_q[1]) | (smp_q[1] & smp_q[2]) | (smp_q[0] & smp_q[2]);
  assign rx_nbits = rxc_q.nine ? 4'h9 : 4'h8;
  assign push = rx_state_q == RX_STOP && baud_tick16 && rx_sub_q == serial_pkg::TICKS_LAST;
  assign stop_bit = vote;
  assign pop = rd && wb_adr_i == serial_pkg::ADDR_RX_DATA && fcount_q != 2'h0;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_state_q <= RX_IDLE;
      rx_sub_q <= 4'h0;
      rx_cnt_q <= 4'h0;
      rsr_q <= 9'h000;
      smp_q <= 3'h7;
      rx_prev_q <= 1'b1;
    end
    else if (!rx_on || overrun_q)
    begin
      rx_state_q <= RX_IDLE;
      rx_prev_q <= 1'b1;
    end
    else if (baud_tick16)
    begin
      rx_prev_q <= receive_pin;
      smp_q <= {smp_q[1:0], receive_pin};
      rx_sub_q <= rx_sub_q + 4'h1;
      unique case (rx_state_q)
        RX_IDLE:
          if (rx_prev_q && !receive_pin)
          begin
            rx_state_q <= RX_START;
            rx_sub_q <= 4'h1;
          end
        RX_START:
          if (rx_sub_q == serial_pkg::TICKS_HALF)
          begin
            // half-bit check; a high line means a glitch, no error
            rx_state_q <= receive_pin ? RX_IDLE : RX_DATA;
            rx_sub_q <= 4'h0;
            rx_cnt_q <= 4'h0;
          end
        RX_DATA:
          if (rx_sub_q == serial_pkg::TICKS_LAST)
          begin
            rsr_q <= rxc_q.nine ? {vote, rsr_q[8:1]} : {1'b0, vote, rsr_q[7:1]};
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q + 4'h1 == rx_nbits)
              rx_state_q <= RX_STOP;
          end
        RX_STOP:
          if (rx_sub_q == serial_pkg::TICKS_LAST)
            rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // receive fifo
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fcount_q <= 2'h0;
      overrun_q <= 1'b0;
      fifo_q[0] <= '0;
      fifo_q[1] <= '0;
    end
    else if (!rxc_q.port_en)
    begin
      fcount_q <= 2'h0;
      overrun_q <= 1'b0;
      fifo_q[0] <= '0;
      fifo_q[1] <= '0;
    end
    else
    begin
      if (!rxc_q.enable)
        overrun_q <= 1'b0;
      else if (push && !pop && fcount_q == serial_pkg::FIFO_DEPTH)
        overrun_q <= 1'b1;
      if (pop)
      begin
        fifo_q[0] <= fifo_q[1];
        if (push && fcount_q == 2'h2)
          fifo_q[1] <= '{data: rsr_q, frame_err: !stop_bit};
        else if (push && fcount_q == 2'h1)
          fifo_q[0] <= '{data: rsr_q, frame_err: !stop_bit};
        if (!push)
          fcount_q <= fcount_q - 2'h1;
      end
      else if (push && fcount_q != serial_pkg::FIFO_DEPTH)
      begin
        fifo_q[fcount_q[0]] <= '{data: rsr_q, frame_err: !stop_bit};
        fcount_q <= fcount_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      receive_irq <= 1'b0;
    else
      receive_irq <= rx_ready && rxc_q.irq_en && rxc_q.periph && rxc_q.global;
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  property p_ready_set;
    @(posedge clk_sys) disable iff (!reset_n)
    (tx_on && txbuf_full_q && !tx_busy_q) |=> tx_busy_q;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("tx ready wrong");

  property p_pin_dir;
    @(posedge clk_sys) disable iff (!reset_n)
    $rose(rxc_q.port_en) |=> transmit_pin_oe;
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin not driven");

  property p_load_idle;
    @(posedge clk_sys) disable iff (!reset_n)
    (buf_write && !tx_busy_q && !txbuf_full_q) |=> ##1 tx_busy_q;
  endproperty
  a_load_idle: assert property (p_load_idle) else $error("idle shifter not loaded");

  property p_full_fifo;
    @(posedge clk_sys) disable iff (!reset_n)
    (push && fcount_q == 2'h2 && !pop && rxc_q.enable && rxc_q.port_en)
      |=> overrun_q && fcount_q == 2'h2;
  endproperty
  a_full_fifo: assert property (p_full_fifo) else $error("overrun missed");

  property p_overrun_block;
    @(posedge clk_sys) disable iff (!reset_n)
    overrun_q |-> rx_state_q == RX_IDLE || !$past(overrun_q);
  endproperty
  a_overrun_block: assert property (p_overrun_block) else $error("rx after overrun");

  property p_rx_irq;
    @(posedge clk_sys) disable iff (!reset_n)
    receive_irq |-> $past(rx_ready) && $past(rxc_q.global);
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx irq without cause");

  property p_tx_irq;
    @(posedge clk_sys) disable iff (!reset_n)
    transmit_irq |-> $past(txc_q.irq_en) && $past(tx_on);
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("tx irq without cause");

  property p_port_off;
    @(posedge clk_sys) disable iff (!reset_n)
    !rxc_q.port_en |=> fcount_q == 2'h0 && !overrun_q && !tx_busy_q;
  endproperty
  a_port_off: assert property (p_port_off) else $error("port off not reset");
endmodule
`default_nettype wire

// >>> core/serial_pkg.sv
// constants, register map and carrier types of the async serial block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`default_nettype none
package serial_pkg;
  // register byte addresses
  localparam logic [3:0] ADDR_TX_CTRL = 4'h0;
  localparam logic [3:0] ADDR_RX_CTRL = 4'h4;
  localparam logic [3:0] ADDR_TX_DATA = 4'h8;
  localparam logic [3:0] ADDR_RX_DATA = 4'hC;
  // transmit control fields
  localparam int TXC_ENABLE = 0;
  localparam int TXC_SYNC = 1;
  localparam int TXC_NINE = 2;
  localparam int TXC_NINTH = 3;
  localparam int TXC_INVERT = 4;
  localparam int TXC_IRQ_EN = 5;
  localparam int TXC_EMPTY = 6;
  localparam int TXC_READY = 7;
  // receive control fields
  localparam int RXC_PORT_EN = 0;
  localparam int RXC_ENABLE = 1;
  localparam int RXC_NINE = 2;
  localparam int RXC_IRQ_EN = 3;
  localparam int RXC_PERIPH = 4;
  localparam int RXC_GLOBAL = 5;
  localparam int RXC_FRAME = 6;
  localparam int RXC_OVERRUN = 7;
  localparam int RXC_READY = 8;
  localparam int RXC_NINTH = 9;
  // timing in 16x ticks, and receive fifo depth in entries
  localparam logic [3:0] TICKS_HALF = 4'h7;
  localparam logic [3:0] TICKS_LAST = 4'hF;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  typedef struct packed {
    logic [8:0] data;
    logic frame_err;
  } rx_entry_t;

  typedef struct packed {
    logic enable;
    logic sync_mode;
    logic nine;
    logic ninth;
    logic invert;
    logic irq_en;
  } tx_ctrl_t;

  typedef struct packed {
    logic port_en;
    logic enable;
    logic nine;
    logic irq_en;
    logic periph;
    logic global;
  } rx_ctrl_t;
endpackage
`default_nettype wire

// >>> verification/remote_serial_partner.sv
// remote asynchronous transceiver facing the serial pins of the block
`timescale 1ns/1ps
`default_nettype none
module remote_serial_partner #(
  parameter int BIT_CLKS = 64
) (
  input wire logic clk_sys,
  input wire logic line_in,
  input wire logic invert,
  input wire logic nine,
  output logic line_out
);
  logic [8:0] rx_q[$];
  int start_q[$];
  int cyc_n = 0;
  int t0;
  int i;
  logic [8:0] shift;
  initial line_out = 1'b1;
  always @(posedge clk_sys) cyc_n <= cyc_n + 1;
  // ------------------------------------------------------------------
  // sender
  // ------------------------------------------------------------------
  // low start, lsb first, chosen stop level, then back to idle high
  task automatic send(input logic [8:0] data, input logic nbit9, input logic stop_lvl);
    int k;
    @(posedge clk_sys);
    line_out <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk_sys);
    for (k = 0; k < (nbit9 ? 9 : 8); k++)
    begin
      line_out <= data[k];
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
    line_out <= stop_lvl;
    repeat (BIT_CLKS) @(posedge clk_sys);
    line_out <= 1'b1;
  endtask
  task automatic glitch(input int n);
    @(posedge clk_sys);
    line_out <= 1'b0;
    repeat (n) @(posedge clk_sys);
    line_out <= 1'b1;
  endtask
  // ------------------------------------------------------------------
  // decoder
  // ------------------------------------------------------------------
  // a start that is gone at its centre is dropped, as polarity flips
  // would otherwise look like frames
  always
  begin
    @(posedge clk_sys);
    if ((line_in ^ invert) === 1'b0)
    begin
      t0 = cyc_n;
      shift = 9'h000;
      repeat (BIT_CLKS / 2) @(posedge clk_sys);
      if ((line_in ^ invert) === 1'b0)
      begin
        start_q.push_back(t0);
        for (i = 0; i < (nine ? 9 : 8); i++)
        begin
          repeat (BIT_CLKS) @(posedge clk_sys);
          shift[i] = line_in ^ invert;
        end
        repeat (BIT_CLKS) @(posedge clk_sys);
        if ((line_in ^ invert) === 1'b1)
          rx_q.push_back(shift);
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/async_serial_tx_rx_tb_top.sv
// self-checking bench for the async serial transmitter and receiver
`timescale 1ns/1ps
`default_nettype none
module async_serial_tx_rx_tb_top;
  localparam int TICK_DIV = 4;
  localparam int BIT_CLKS = 16 * TICK_DIV;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic baud_tick16 = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, rx_line, transmit_pin_o, transmit_pin_oe, transmit_irq, receive_irq;
  logic inv = 1'b0;
  logic nine_sel = 1'b0;
  int tick_cnt = 0;
  int seed = 32'hff3a;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [31:0] q, r;
  logic [8:0] d0, d1;
  logic [8:0] dq[3];
  always #12.5 clk_sys = ~clk_sys;
  // fixed divide keeps every bit but a start bit loaded off a tick edge exactly BIT_CLKS system cycles long
  always @(posedge clk_sys)
  begin
    tick_cnt <= (tick_cnt + 1) % TICK_DIV;
    baud_tick16 <= (tick_cnt == TICK_DIV - 1);
  end
  async_serial_tx_rx dut (.clk_sys(clk_sys), .reset_n(reset_n), .baud_tick16(baud_tick16),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .receive_pin(rx_line), .transmit_pin_o(transmit_pin_o), .transmit_pin_oe(transmit_pin_oe),
    .transmit_irq(transmit_irq), .receive_irq(receive_irq));
  remote_serial_partner #(.BIT_CLKS(BIT_CLKS)) u_partner (.clk_sys(clk_sys),
    .line_in(transmit_pin_o), .invert(inv), .nine(nine_sel), .line_out(rx_line));
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      n_mismatch++;
      summarize;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic wait_rx(input int n);
    int t;
    t = 0;
    while (u_partner.rx_q.size() < n && t < 1200 * n)
    begin
      @(posedge clk_sys);
      t++;
    end
    check("frames", 32'(u_partner.rx_q.size()), 32'(n));
    if (u_partner.rx_q.size() < n)
      summarize;
  endtask
  function automatic logic [31:0] exp_tx(input logic [5:0] c, input logic mt, input logic rdy);
    return {24'h0, rdy, mt, c};
  endfunction
  function automatic logic [31:0] exp_rx(input logic [5:0] c, input logic fr, input logic ov,
    input logic rdy);
    return {23'h0, rdy, ov, fr, c};
  endfunction
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    n_mismatch++;
    summarize;
  end
  initial
  begin
    repeat (10) @(posedge clk_sys);
    check("pins_rst", {30'h0, transmit_pin_oe, transmit_pin_o}, 32'h1);
    reset_n <= 1'b1;
    wb(serial_pkg::ADDR_TX_CTRL, 1'b0, 32'h0);
    check("tx_rst", q, exp_tx(6'h00, 1'b1, 1'b0));
    wb(4'h2, 1'b0, 32'h0);
    check("unmapped", q, 32'h0);
    wb(serial_pkg::ADDR_RX_CTRL, 1'b1, 32'h1);
    settle;
    check("pin_oe", {31'h0, transmit_pin_oe}, 32'h1);
    wb(serial_pkg::ADDR_TX_CTRL, 1'b1, 32'h21);
    settle;
    wb(serial_pkg::ADDR_TX_CTRL, 1'b0, 32'h0);
    check("tx_on", q, exp_tx(6'h21, 1'b1, 1'b1));
    check("tx_irq", {31'h0, transmit_irq}, 32'h1);
    r = $random(seed);
    d0 = {1'b0, r[7:0]};
    d1 = {1'b0, r[15:8]};
    // load lands on a tick edge, so the first start bit is a whole bit long
    @(posedge clk_sys);
    while (baud_tick16 !== 1'b1)
      @(posedge clk_sys);
    @(posedge clk_sys);
    wb(serial_pkg::ADDR_TX_DATA, 1'b1, {24'h0, d0[7:0]});
    wb(serial_pkg::ADDR_TX_DATA, 1'b1, {24'h0, d1[7:0]});
    wb(serial_pkg::ADDR_TX_CTRL, 1'b0, 32'h0);
    check("tx_queued", q, exp_tx(6'h21, 1'b0, 1'b0));
    check("tx_irq_q", {31'h0, transmit_irq}, 32'h0);
    wait_rx(2);
    check("tx_d0", {23'h0, u_partner.rx_q.pop_front()}, {23'h0, d0});
    check("tx_d1", {23'h0, u_partner.rx_q.pop_front()}, {23'h0, d1});
    check("gap", 32'(u_partner.start_q[1] - u_partner.start_q[0]), 32'(10 * BIT_CLKS));
    repeat (BIT_CLKS) @(posedge clk_sys);
    wb(serial_pkg::ADDR_TX_CTRL, 1'b0, 32'h0);
    check("tx_drain", q, exp_tx(6'h21, 1'b1, 1'b1));
    nine_sel <= 1'b1;
    d0 = {1'b1, r[23:16]};
    wb(serial_pkg::ADDR_TX_CTRL, 1'b1, 32'h0D);
    wb(serial_pkg::ADDR_TX_DATA, 1'b1, {24'h0, d0[7:0]});
    wait_rx(1);
    check("tx_nine", {23'h0, u_partner.rx_q.pop_front()}, {23'h0, d0});
    repeat (BIT_CLKS) @(posedge clk_sys);
    nine_sel <= 1'b0;
    inv <= 1'b1;
    wb(serial_pkg::ADDR_TX_CTRL, 1'b1, 32'h11);
    // let the partner drop the false start made by the polarity flip
    repeat (BIT_CLKS) @(posedge clk_sys);
    check("idle_inv", {31'h0, transmit_pin_o}, 32'h0);
    d0 = {1'b0, r[31:24]};
    wb(serial_pkg::ADDR_TX_DATA, 1'b1, {24'h0, d0[7:0]});
    wait_rx(1);
    check("tx_inv", {23'h0, u_partner.rx_q.pop_front()}, {23'h0, d0});
    repeat (BIT_CLKS) @(posedge clk_sys);
    wb(serial_pkg::ADDR_TX_CTRL, 1'b1, 32'h00);
    inv <= 1'b0;
    wb(serial_pkg::ADDR_TX_DATA, 1'b1, 32'h55);
    wb(serial_pkg::ADDR_TX_CTRL, 1'b0, 32'h0);
    check("tx_off", q, exp_tx(6'h00, 1'b1, 1'b0));
    wb(serial_pkg::ADDR_RX_CTRL, 1'b1, 32'h3B);
    r = $random(seed);
    u_partner.send({1'b0, r[7:0]}, 1'b0, 1'b1);
    settle;
    wb(serial_pkg::ADDR_RX_CTRL, 1'b0, 32'h0);
    check("rx_ready", q & 32'h1FF, exp_rx(6'h3B, 1'b0, 1'b0, 1'b1));
    check("rx_irq", {31'h0, receive_irq}, 32'h1);
    wb(serial_pkg::ADDR_RX_CTRL, 1'b1, 32'h1B);
    settle;
    check("rx_irq_gate", {31'h0, receive_irq}, 32'h0);
    wb(serial_pkg::ADDR_RX_DATA, 1'b0, 32'h0);
    check("rx_data", q & 32'hFF, {24'h0, r[7:0]});
    wb(serial_pkg::ADDR_RX_CTRL, 1'b0, 32'h0);
    check("rx_empty", q & 32'h1FF, exp_rx(6'h1B, 1'b0, 1'b0, 1'b0));
    u_partner.send({1'b0, r[15:8]}, 1'b0, 1'b0);
    settle;
    wb(serial_pkg::ADDR_RX_CTRL, 1'b0, 32'h0);
    check("rx_frame", q & 32'h1FF, exp_rx(6'h1B, 1'b1, 1'b0, 1'b1));
    wb(serial_pkg::ADDR_RX_CTRL, 1'b1, 32'h01);
    wb(serial_pkg::ADDR_RX_CTRL, 1'b0, 32'h0);
    check("frame_keep", q & 32'h1FF, exp_rx(6'h01, 1'b1, 1'b0, 1'b0));
    wb(serial_pkg::ADDR_RX_CTRL, 1'b1, 32'h00);
    wb(serial_pkg::ADDR_RX_CTRL, 1'b0, 32'h0);
    check("port_off", q & 32'h1FF, exp_rx(6'h00, 1'b0, 1'b0, 1'b0));
    wb(serial_pkg::ADDR_RX_CTRL, 1'b1, 32'h3B);
    foreach (dq[k])
    begin
      r = $random(seed);
      dq[k] = {1'b0, r[7:0]};
      u_partner.send(dq[k], 1'b0, 1'b1);
    end
    settle;
    wb(serial_pkg::ADDR_RX_CTRL, 1'b0, 32'h0);
    check("overrun", q & 32'h1FF, exp_rx(6'h3B, 1'b0, 1'b1, 1'b1));
    wb(serial_pkg::ADDR_RX_DATA, 1'b0, 32'h0);
    check("fifo0", q & 32'hFF, {24'h0, dq[0][7:0]});
    wb(serial_pkg::ADDR_RX_DATA, 1'b0, 32'h0);
    check("fifo1", q & 32'hFF, {24'h0, dq[1][7:0]});
    wb(serial_pkg::ADDR_RX_CTRL, 1'b0, 32'h0);
    check("third_lost", q & 32'h1FF, exp_rx(6'h3B, 1'b0, 1'b1, 1'b0));
    wb(serial_pkg::ADDR_RX_CTRL, 1'b1, 32'h39);
    wb(serial_pkg::ADDR_RX_CTRL, 1'b1, 32'h3B);
    wb(serial_pkg::ADDR_RX_CTRL, 1'b0, 32'h0);
    check("ovr_clear", q & 32'h1FF, exp_rx(6'h3B, 1'b0, 1'b0, 1'b0));
    u_partner.glitch(8);
    repeat (12 * BIT_CLKS) @(posedge clk_sys);
    wb(serial_pkg::ADDR_RX_CTRL, 1'b0, 32'h0);
    check("glitch", q & 32'h1FF, exp_rx(6'h3B, 1'b0, 1'b0, 1'b0));
    u_partner.send(dq[2], 1'b0, 1'b1);
    settle;
    wb(serial_pkg::ADDR_RX_DATA, 1'b0, 32'h0);
    check("after_glitch", q & 32'hFF, {24'h0, dq[2][7:0]});
    wb(serial_pkg::ADDR_RX_CTRL, 1'b1, 32'h3F);
    d1 = {r[24], r[23:16]};
    u_partner.send(d1, 1'b1, 1'b1);
    settle;
    wb(serial_pkg::ADDR_RX_CTRL, 1'b0, 32'h0);
    check("rx_ninth", q & 32'h3FF, exp_rx(6'h3F, 1'b0, 1'b0, 1'b1) | {22'h0, d1[8], 9'h0});
    wb(serial_pkg::ADDR_RX_DATA, 1'b0, 32'h0);
    check("rx_nine", q & 32'hFF, {24'h0, d1[7:0]});
    summarize;
  end
endmodule
`default_nettype wire
